/* File: rtl/pactl_params.svh */
`ifndef PACTL_PARAMS_SVH
`define PACTL_PARAMS_SVH
// Register byte offsets on the APB bus
`define PACTL_OFF_PIN_LEVEL    12'h000
`define PACTL_OFF_OUT_LATCH    12'h004
`define PACTL_OFF_DIRECTION    12'h008
`define PACTL_OFF_CONFIG       12'h00c
// Field positions
`define PACTL_PIN_CYC_CLK      6
`define PACTL_PIN_CMP_ONE      4
`define PACTL_PIN_CMP_TWO      5
`define PACTL_PIN_REF_OUT      2
`define PACTL_PIN_RX           4
// Config register fields
`define PACTL_CFG_OSC_LSB      0
`define PACTL_CFG_C1OE_BIT     4
`define PACTL_CFG_C2OE_BIT     5
`define PACTL_CFG_REF_OUT_BIT  6
`define PACTL_CFG_ANA_LSB      8
// Reset values
`define PACTL_RST_LATCH        7'h00
`define PACTL_RST_DIR          7'h7f
`define PACTL_RST_ANALOG       7'h2f
`define PACTL_RST_OSC          4'h0
// Quarter-rate divider output bit of the count
`define PACTL_CYC_DIV_HALF     1'h1
`endif

/* File: rtl/pactl_pkg.sv */
`default_nettype none
package pactl_pkg;
  // Oscillator mode selection
  typedef enum logic [3:0] {
    PACTL_OSC_XT        = 4'h0,
    PACTL_OSC_EXT       = 4'h1,
    PACTL_OSC_EXT_IO    = 4'h2,
    PACTL_OSC_EXT_PLL   = 4'h3,
    PACTL_OSC_EXT_PLLIO = 4'h4,
    PACTL_OSC_INT_IO    = 4'h5,
    PACTL_OSC_INT_CKO   = 4'h6,
    PACTL_OSC_HS        = 4'h7
  } pactl_osc_t;
endpackage
`default_nettype wire

/* File: rtl/pactl_pin_if.sv */
`default_nettype none
// Per-pin control bundle between the port core and the synchroniser
interface pactl_pin_if #(parameter int W = 7);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport core (input synced);
  modport sync (input raw, output synced);
endinterface
`default_nettype wire

/* File: rtl/pactl_sync3.sv */
`default_nettype none
// Three-stage synchroniser; change taken once stages two and three agree
module pactl_sync3 #(
  parameter int W = 7
) (
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  pactl_pin_if.sync pins
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // A port needs at least one pin
  if (W < 1)
  begin : g_bad_width
    $error("pactl_sync3: width must be at least one");
  end

  // Accept new level only when the last two stages match
  always_comb
  begin
    out_d = out_q;
    for (int i = 0; i < W; i++)
      if (s2_q[i] == s3_q[i])
        out_d[i] = s3_q[i];
  end

  // Register stages
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end
    else
    begin
      s1_q  <= pins.raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end
  assign pins.synced = out_q;
endmodule
`default_nettype wire

/* File: rtl/pactl_clkdiv.sv */
`default_nettype none
`include "pactl_params.svh"
// Divides the core clock by four to make the cycle clock
module pactl_clkdiv (
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  output logic      o_clk_div4
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  // Free-running count; top bit is a 50% duty quarter-rate clock
  always_comb
  begin
    cnt_d = cnt_q + 2'h1;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cnt_q <= 2'h0;
    else
      cnt_q <= cnt_d;
  end
  assign o_clk_div4 = cnt_q[`PACTL_CYC_DIV_HALF];
endmodule
`default_nettype wire

/* File: rtl/pactl_port.sv */
// The implementer's own choices: the APB slave port and the register addresses.
`default_nettype none
`include "pactl_params.svh"
module pactl_port (
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  i_pin,
  output logic      [6:0]  o_pin,
  output logic      [6:0]  o_pin_oe,
  input  wire logic        i_comparator_one_result,
  input  wire logic        i_comparator_two_result,
  output logic             o_reference_voltage_out_en,
  output logic             o_usb_receive_in,
  output logic             o_timer_zero_clock_in
);
  //////////////////////////////////////////////////////////////////////////
  logic [6:0]  latch_q, latch_d;
  logic [6:0]  dir_q, dir_d;
  logic [6:0]  ana_q, ana_d;
  logic [3:0]  osc_q, osc_d;
  logic        c1oe_q, c1oe_d;
  logic        c2oe_q, c2oe_d;
  logic        cvr_q, cvr_d;
  logic [31:0] rdata_q, rdata_d;
  logic        rdy_q, rdy_d;
  logic        err_q, err_d;
  logic [6:0]  pin_q, pin_d;
  logic [6:0]  oe_q, oe_d;
  logic        rx_q, rx_d;
  logic        tck_q, tck_d;
  logic        cvo_q, cvo_d;
  logic [6:0]  syn;
  logic        clk4;
  logic        gpio6;
  logic        cycle_clock_out_mode;
  logic [6:0]  dig_in;
  logic        access;

  pactl_pin_if #(.W(7)) pif ();
  assign pif.raw = i_pin;
  assign syn     = pif.synced;

  pactl_sync3 #(.W(7)) u_sync (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .pins       (pif)
  );

  pactl_clkdiv u_div (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .o_clk_div4 (clk4)
  );

  //////////////////////////////////////////////////////////////////////////
  // Oscillator mode decode
  always_comb
  begin
    gpio6 = (osc_q == pactl_pkg::PACTL_OSC_EXT_IO)
         || (osc_q == pactl_pkg::PACTL_OSC_EXT_PLLIO)
         || (osc_q == pactl_pkg::PACTL_OSC_INT_IO);
    cycle_clock_out_mode = (osc_q == pactl_pkg::PACTL_OSC_EXT)
             || (osc_q == pactl_pkg::PACTL_OSC_EXT_PLL)
             || (osc_q == pactl_pkg::PACTL_OSC_INT_CKO);
  end

  // Digital input view: analog-selected or dead pins read zero
  always_comb
  begin
    dig_in = syn & ~ana_q;
    if (cvr_q)
      dig_in[`PACTL_PIN_REF_OUT] = 1'b0;
    if (!gpio6)
      dig_in[`PACTL_PIN_CYC_CLK] = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // APB slave: access phase with one wait state, registered answer
  assign access = psel && penable && !rdy_q;

  always_comb
  begin
    latch_d = latch_q;
    dir_d   = dir_q;
    ana_d   = ana_q;
    osc_d   = osc_q;
    c1oe_d  = c1oe_q;
    c2oe_d  = c2oe_q;
    cvr_d   = cvr_q;
    rdata_d = '0;
    rdy_d   = access;
    err_d   = 1'b0;
    if (access && pwrite)
    begin
      unique case (paddr)
        `PACTL_OFF_PIN_LEVEL, `PACTL_OFF_OUT_LATCH:
          latch_d = pwdata[6:0];
        `PACTL_OFF_DIRECTION:
          dir_d = pwdata[6:0];
        `PACTL_OFF_CONFIG:
        begin
          osc_d  = pwdata[`PACTL_CFG_OSC_LSB +: 4];
          c1oe_d = pwdata[`PACTL_CFG_C1OE_BIT];
          c2oe_d = pwdata[`PACTL_CFG_C2OE_BIT];
          cvr_d  = pwdata[`PACTL_CFG_REF_OUT_BIT];
          ana_d  = pwdata[`PACTL_CFG_ANA_LSB +: 7];
        end
        default:
          err_d = 1'b1;
      endcase
    end
    else if (access)
    begin
      unique case (paddr)
        `PACTL_OFF_PIN_LEVEL:
          rdata_d = {25'h0, dig_in};
        `PACTL_OFF_OUT_LATCH:
          rdata_d = {25'h0, gpio6 & latch_q[6], latch_q[5:0]};
        `PACTL_OFF_DIRECTION:
          rdata_d = {25'h0, gpio6 & dir_q[6], dir_q[5:0]};
        `PACTL_OFF_CONFIG:
          rdata_d = {17'h0, ana_q, 1'b0, cvr_q, c2oe_q, c1oe_q, osc_q};
        default:
          err_d = 1'b1;
      endcase
    end
    // Pin-6 state is frozen while it is not a port pin
    if (!gpio6)
    begin
      latch_d[6] = latch_q[6];
      dir_d[6]   = dir_q[6];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin drivers and alternate functions
  always_comb
  begin
    pin_d = latch_q;
    oe_d  = ~dir_q;
    if (c1oe_q && !dir_q[`PACTL_PIN_CMP_ONE])
      pin_d[`PACTL_PIN_CMP_ONE] = i_comparator_one_result;
    if (c2oe_q && !dir_q[`PACTL_PIN_CMP_TWO])
      pin_d[`PACTL_PIN_CMP_TWO] = i_comparator_two_result;
    if (cvr_q)
    begin
      pin_d[`PACTL_PIN_REF_OUT] = 1'b0;
      oe_d[`PACTL_PIN_REF_OUT]  = 1'b0;
    end
    if (cycle_clock_out_mode)
    begin
      pin_d[`PACTL_PIN_CYC_CLK] = clk4;
      oe_d[`PACTL_PIN_CYC_CLK]  = 1'b1;
    end
    else if (!gpio6)
    begin
      pin_d[`PACTL_PIN_CYC_CLK] = 1'b0;
      oe_d[`PACTL_PIN_CYC_CLK]  = 1'b0;
    end
    rx_d  = syn[`PACTL_PIN_RX];
    tck_d = dir_q[`PACTL_PIN_RX] & syn[`PACTL_PIN_RX];
    cvo_d = cvr_q;
  end

  // State registers
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      latch_q <= `PACTL_RST_LATCH;
      dir_q   <= `PACTL_RST_DIR;
      ana_q   <= `PACTL_RST_ANALOG;
      osc_q   <= `PACTL_RST_OSC;
      c1oe_q  <= 1'b0;
      c2oe_q  <= 1'b0;
      cvr_q   <= 1'b0;
      rdata_q <= '0;
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      pin_q   <= '0;
      oe_q    <= '0;
      rx_q    <= 1'b0;
      tck_q   <= 1'b0;
      cvo_q   <= 1'b0;
    end
    else
    begin
      latch_q <= latch_d;
      dir_q   <= dir_d;
      ana_q   <= ana_d;
      osc_q   <= osc_d;
      c1oe_q  <= c1oe_d;
      c2oe_q  <= c2oe_d;
      cvr_q   <= cvr_d;
      rdata_q <= rdata_d;
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      pin_q   <= pin_d;
      oe_q    <= oe_d;
      rx_q    <= rx_d;
      tck_q   <= tck_d;
      cvo_q   <= cvo_d;
    end
  end

  assign prdata  = rdata_q;
  assign pready  = rdy_q;
  assign pslverr = err_q;
  assign o_pin   = pin_q;
  assign o_pin_oe = oe_q;
  assign o_usb_receive_in = rx_q;
  assign o_timer_zero_clock_in = tck_q;
  assign o_reference_voltage_out_en = cvo_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  out_drive_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (!dir_q[0] ##1 !$past(dir_q[0]))
    |-> o_pin_oe[0] && o_pin[0] == $past(latch_q[0]))
    else $error("pin 0 not driving latch");
  tri_state_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    dir_q[3] |=> !o_pin_oe[3])
    else $error("input pin driven");
  ana_block_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    access && !pwrite && paddr == `PACTL_OFF_PIN_LEVEL && ana_q[1]
    |=> prdata[1] == 1'b0)
    else $error("analog pin read nonzero");
  cmp_over_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    c1oe_q && !dir_q[4] |=> o_pin[4] == $past(i_comparator_one_result))
    else $error("comparator not on pin 4");
  reference_voltage_out_off_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    cvr_q |=> !o_pin_oe[2])
    else $error("pin 2 driven with reference on");
  cycle_clock_out_run_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    cycle_clock_out_mode ##1 cycle_clock_out_mode |-> o_pin_oe[6])
    else $error("cycle clock not driven");
  bit7_zero_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    pready |-> prdata[31:7] == '0 || paddr == `PACTL_OFF_CONFIG)
    else $error("unimplemented bits nonzero");
  pin6_dead_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    access && !pwrite && paddr == `PACTL_OFF_DIRECTION && !gpio6
    |=> prdata[6] == 1'b0)
    else $error("pin 6 direction visible");
  usb_rx_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    1'b1 |=> o_usb_receive_in == $past(syn[4]))
    else $error("receive input not following pin 4");
  lvl_write_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    access && pwrite && paddr == `PACTL_OFF_PIN_LEVEL
    |=> latch_q[5:0] == $past(pwdata[5:0]))
    else $error("pin level write missed the latch");
  lat_read_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    access && !pwrite && paddr == `PACTL_OFF_OUT_LATCH
    |=> prdata[5:0] == $past(latch_q[5:0]))
    else $error("latch read not showing the latch");
  pin6_hold_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    !gpio6 |=> latch_q[6] == $past(latch_q[6])
            && dir_q[6] == $past(dir_q[6]))
    else $error("pin 6 state changed while not a port pin");
  ana_drive_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    ana_q[3] && !dir_q[3]
    |=> o_pin_oe[3] && o_pin[3] == $past(latch_q[3]))
    else $error("analog pin 3 lost its output driver");
  ref_in_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    access && !pwrite && paddr == `PACTL_OFF_PIN_LEVEL && cvr_q
    |=> prdata[`PACTL_PIN_REF_OUT] == 1'b0)
    else $error("pin 2 input visible with reference on");
  tmr_in_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    1'b1 |=> o_timer_zero_clock_in == ($past(dir_q[4]) && $past(syn[4])))
    else $error("timer input not gated by direction");
  cmp_two_a: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    c2oe_q && !dir_q[5] |=> o_pin[5] == $past(i_comparator_two_result))
    else $error("comparator not on pin 5");
endmodule
`default_nettype wire

/* File: verification/pactl_board.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Board side: drives every pin that the device leaves undriven
module pactl_board (
  input  wire logic [6:0] i_pin_out,
  input  wire logic [6:0] i_pin_oe,
  input  wire logic [6:0] i_board_val,
  output logic      [6:0] o_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // Device driver wins where enabled, the board drives the rest
  always_comb
  begin
    o_level = (i_pin_out & i_pin_oe) | (i_board_val & ~i_pin_oe);
  end
endmodule
`default_nettype wire

/* File: verification/pactl_tb.sv */
`default_nettype none
module port_a_pin_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_core_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [6:0]  lvl;
  logic [6:0]  pout;
  logic [6:0]  poe;
  logic [6:0]  bv = 7'h00;
  logic        cmp_a = 1'b0;
  logic        cmp_b = 1'b0;
  logic        vref;
  logic        usb;
  logic        tmr;
  int          fails = 0;
  int          cmp_count = 0;
  logic [15:0] seed = 16'h1853;
  logic [31:0] rd;
  logic        err;
  logic [15:0] a;
  logic [15:0] b;
  logic [6:0]  nd;
  logic        w4;
  logic [5:0]  s;
  ////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #2.5 i_core_clk = ~i_core_clk;
  pactl_port i_dut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_pin(lvl), .o_pin(pout), .o_pin_oe(poe),
    .i_comparator_one_result(cmp_a), .i_comparator_two_result(cmp_b),
    .o_reference_voltage_out_en(vref), .o_usb_receive_in(usb),
    .o_timer_zero_clock_in(tmr));
  pactl_board i_board (.i_pin_out(pout), .i_pin_oe(poe),
    .i_board_val(bv), .o_level(lvl));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus tasks
  task automatic report_and_stop();
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    int n;
    @(posedge i_core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    for (n = 0; n < 50 && pready !== 1'b1; n++)
      @(posedge i_core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
    begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rdc(input string nm, input logic [11:0] ad,
                     input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // Expectation helpers and the random source
  function automatic logic [31:0] cfg(logic [3:0] m, logic [6:0] an,
                                      logic [2:0] en);
    return {17'h0, an, 1'b0, en, m};
  endfunction
  function automatic logic [15:0] nxt(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic io6(int m);
    return m == 2 || m == 4 || m == 5;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    tick(12);
    i_arst_n <= 1'b1;
    bv <= 7'h7f;
    tick(8);
    rdc("lvl_rst", 12'h000, 32'h10);
    rdc("dir_rst", 12'h008, 32'h3f);
    chk("oe_rst", 32'h0, {26'h0, poe[5:0]});
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("rd_unmapped", 32'h0, rd);
    wr(12'h010, 32'h7f);
    chk("wr_err", 32'h1, {31'h0, err});
    rdc("lat_err", 12'h004, 32'h0);
    // Analog pins still drive their latch
    wr(12'h008, 32'h0);
    wr(12'h004, 32'hffffffef);
    tick(3);
    chk("out_ana", 32'h2f, {26'h0, pout[5:0]});
    chk("oe_ana", 32'h3f, {26'h0, poe[5:0]});
    rdc("lat_ana", 12'h004, 32'h2f);
    rdc("lvl_ana", 12'h000, 32'h0);
    // Random latch, direction and board traffic with corners first
    wr(12'h00c, cfg(4'h5, 7'h00, 3'h0));
    for (int i = 0; i < 10; i++)
    begin
      seed = nxt(seed);
      a = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : seed;
      seed = nxt(seed);
      b = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : seed;
      nd = ~b[6:0];
      wr(i[0] ? 12'h000 : 12'h004, {b, a});
      wr(12'h008, {a, b});
      bv <= a[13:7];
      tick(8);
      w4 = b[4] ? a[11] : a[4];
      rdc("lat", 12'h004, {25'h0, a[6:0]});
      rdc("dir", 12'h008, {25'h0, b[6:0]});
      chk("oe", {25'h0, nd}, {25'h0, poe});
      chk("out", {25'h0, a[6:0] & nd}, {25'h0, pout & nd});
      rdc("lvl", 12'h000,
          {25'h0, (a[6:0] & nd) | (a[13:7] & b[6:0])});
      chk("usb", {31'h0, w4}, {31'h0, usb});
      chk("tmr", {31'h0, w4 & b[4]}, {31'h0, tmr});
    end
    // Analog inputs block the digital input path
    wr(12'h00c, cfg(4'h5, 7'h2f, 3'h0));
    wr(12'h008, 32'h7f);
    bv <= 7'h7f;
    tick(8);
    rdc("lvl_an_in", 12'h000, 32'h50);
    rdc("cfg", 12'h00c, cfg(4'h5, 7'h2f, 3'h0));
    // Reference output disables pin 2 even while it is set as an output
    wr(12'h008, 32'h0);
    wr(12'h004, 32'h7f);
    wr(12'h00c, cfg(4'h5, 7'h00, 3'h4));
    tick(8);
    chk("vref", 32'h1, {31'h0, vref});
    chk("oe_vref", 32'h7b, {25'h0, poe});
    rdc("lvl_vref", 12'h000, 32'h7b);
    // Comparator results override the latch on pins 4 and 5
    wr(12'h00c, cfg(4'h5, 7'h00, 3'h3));
    wr(12'h004, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      cmp_a <= k[0];
      cmp_b <= k[1];
      tick(5);
      chk("cmp", {30'h0, k[1], k[0]}, {30'h0, pout[5:4]});
    end
    // Pin 6 per oscillator mode: general pin, quarter-rate clock, or dead
    for (int m = 0; m < 8; m++)
    begin
      wr(12'h00c, cfg(m[3:0], 7'h00, 3'h0));
      wr(12'h004, 32'h7f);
      rdc("lat6", 12'h004, io6(m) ? 32'h7f : 32'h3f);
      if (m == 1 || m == 3 || m == 6)
      begin
        for (int j = 0; j < 6; j++)
        begin
          @(posedge i_core_clk);
          s[j] = pout[6];
        end
        chk("cycle_clock_out", {30'h0, s[0], ~s[0]}, {30'h0, s[4], s[2]});
        chk("cycle_clock_out_oe", 32'h1, {31'h0, poe[6]});
      end
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
